// [include/acc_pkg.sv]
// Contract
// - Chop enable bit, one on, resets zero
// - Four-bit chop delay in bits 12:9, reset 0011b
// - Two-bit channel-0 input select, bits 1:0
// - Offset high register holds offset bits 23:8
// - Offset low byte holds bits 7:0, low reads zero
// - Gain high resets 8000h; chop register 0600h
// - Spare b 7:4 and channel 5:3 read zero
// - Gain high register holds gain bits 23:8
`default_nettype none
package acc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] ACC_IDX_CHOP   = 4'h6;
    localparam logic [3:0] ACC_IDX_SPAREA = 4'h7;
    localparam logic [3:0] ACC_IDX_SPAREB = 4'h8;
    localparam logic [3:0] ACC_IDX_CH0CFG = 4'h9;
    localparam logic [3:0] ACC_IDX_OFSHI  = 4'ha;
    localparam logic [3:0] ACC_IDX_OFSLO  = 4'hb;
    localparam logic [3:0] ACC_IDX_GAINHI = 4'hc;
    // Word index sits above the two byte-offset bits
    localparam int ACC_IDX_LSB = 2;
    localparam int ACC_IDX_MSB = 5;
    // Reset values
    localparam logic [15:0] ACC_RST_CHOP   = 16'h0600;
    localparam logic [15:0] ACC_RST_ZERO   = 16'h0000;
    localparam logic [15:0] ACC_RST_GAINHI = 16'h8000;
    // Storable bit masks; cleared bits are read-only zero
    localparam logic [15:0] ACC_MASK_ALL    = 16'hffff;
    localparam logic [15:0] ACC_MASK_SPAREB = 16'hff0f;
    localparam logic [15:0] ACC_MASK_CH0CFG = 16'hffc7;
    localparam logic [15:0] ACC_MASK_OFSLO  = 16'hff00;
    // Field positions
    localparam int ACC_CHOP_EN_BIT = 8;
    localparam int ACC_DLY_LSB     = 9;
    localparam int ACC_DLY_MSB     = 12;
    localparam int ACC_SEL_LSB     = 0;
    localparam int ACC_SEL_MSB     = 1;
    localparam int ACC_LOB_LSB     = 8;
    localparam int ACC_LOB_MSB     = 15;
    // Settle count width covers 65536 periods
    localparam int ACC_CNT_W = 17;
    localparam logic [3:0]  ACC_DLY_ODD  = 4'hd;
    localparam logic [16:0] ACC_ODD_CNT  = 17'h04064;
    localparam logic [16:0] ACC_BASE_CNT = 17'h00002;
    // Settle timer states
    typedef enum logic {ACC_IDLE, ACC_SETTLE} acc_state_t;
endpackage
`default_nettype wire

// [logic/acc_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module acc_regs
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Conversion timing, same clock domain
    input  wire logic        CONV_START,
    input  wire logic        MOD_TICK,
    input  wire logic        PHASE_FLIP,
    // Configuration toward the datapath
    output logic             CHOP_MODE_ON,
    output logic [3:0]       CHOP_SETTLE_DELAY,
    output logic             CHOP_SETTLING,
    output logic [1:0]       CHANNEL0_INPUT_SELECT,
    output logic [23:0]      CHANNEL0_OFFSET,
    output logic [23:0]      CHANNEL0_GAIN
);

    // Stored register words
    logic [15:0] chop_reg;
    logic [15:0] sparea_reg;
    logic [15:0] spareb_reg;
    logic [15:0] ch0cfg_reg;
    logic [15:0] ofshi_reg;
    logic [15:0] ofslo_reg;
    logic [15:0] gainhi_reg;

    // Bus handshake state
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;

    // Decoded access
    logic [3:0]  idx;
    logic        hit;
    logic        in_range;
    logic        wr_stb;
    logic [15:0] wdata;
    logic [15:0] rd_mux;

    // Active calibration words, latched per conversion
    logic [23:0] ofs_act_reg;
    logic [23:0] gain_act_reg;
    logic [1:0]  sel_act_reg;

    // Settle timer
    acc_state_t           state_reg;
    logic [ACC_CNT_W-1:0] cnt_reg;
    logic [ACC_CNT_W-1:0] dly_cnt;

    // Overview of the register map
    // Index 6: chop configuration word
    //   Bit 8 switches chop mode on
    //   Bits 12:9 pick the settle delay code
    //   Other bits are reserved storage
    // Index 7: spare word a, plain storage
    // Index 8: spare word b
    //   Bits 7:4 are read-only zero
    // Index 9: channel-0 configuration
    //   Bits 1:0 pick the input source
    //   Bits 5:3 are read-only zero
    // Index 10: offset bits 23:8
    // Index 11: offset bits 7:0 in the upper byte
    //   Low byte is read-only zero
    // Index 12: gain bits 23:8
    // Byte address is four times the index
    // All words sit in the low half of the data bus
    // The upper half always reads zero

    // Bus timing overview
    // Setup cycle: select high, enable low
    // First access cycle: ready still low
    // Second access cycle: ready high
    // Write lands at the edge that samples ready high
    // Read data stands only in the ready cycle
    // Error flag stands only in the ready cycle
    // Back to back transfers are accepted
    // Ready is a register, so the wait is fixed
    // A fixed wait trades speed for a clean answer

    // Refused accesses
    // Indices outside 6 to 12 raise the error flag
    // Nonzero upper address bits raise the error flag
    // Nonzero byte-offset bits raise the error flag
    // A refused write changes nothing
    // A refused read returns zero

    // Input source codes
    // Code 0: channel pins connected
    // Code 1: pins open, converter inputs shorted
    // Code 2: positive test level applied
    // Code 3: negative test level applied

    // Settle delay codes
    // Code k waits two times two to the k periods
    // Code 13 waits the odd count kept in the package
    // Code 14 is undefined and keeps doubling
    // Code 15 waits the longest count
    // Periods are counted on modulator ticks
    // The tick input must pulse once per period

    // Settle timer behaviour
    // A phase flip with chop on starts the wait
    // A phase flip with chop off is ignored
    // A new flip during a wait restarts the count
    // Turning chop off ends the wait at once
    // The settling flag falls on the last tick
    // A limitation: the counter is loaded on every flip,
    // even with chop off, but it is read only in a wait

    // Calibration and select handling
    // Host writes go to stored words first
    // Conversion start copies them to the outputs
    // So a write never tears a running conversion
    // Offset is two's complement, 24 bits
    // Gain is unsigned, 24 bits, below two
    // Gain low byte lives outside this block
    // It is taken as zero here
    // Reset values stand until the first start

    // Reserved fields
    // Read/write reserved bits are stored as written
    // The host is expected to keep them zero
    // Read-only bits never store and read zero
    // Masks for them live in the package

    // Reset behaviour
    // Reset is synchronous and active low
    // Bus outputs are zero during reset
    // Register words take their reset values
    // The settle timer returns to idle
    // A transfer may start right after release

    // Clocking
    // Everything runs on the one system clock
    // Timing inputs come from the same domain
    // So no synchroniser stages are needed
    // Every output comes from a flip-flop

    // Word index from the byte address
    assign idx = PADDR[ACC_IDX_MSB:ACC_IDX_LSB];

    // Mapped words sit at indices 6 to 12, word aligned
    assign in_range = (idx >= ACC_IDX_CHOP) && (idx <= ACC_IDX_GAINHI);

    // Whole address must match; upper bits must be zero
    assign hit = in_range
              && (PADDR[31:ACC_IDX_MSB+1] == '0)
              && (PADDR[ACC_IDX_LSB-1:0] == '0);

    // A write lands only at the completing edge
    assign wr_stb = PSEL && PENABLE && pready_reg && PWRITE && hit;

    // Registers are 16 bits wide in the low lanes
    assign wdata = PWDATA[15:0];

    // Read multiplexer; masked bits read back as zero
    always_comb begin
        rd_mux = ACC_RST_ZERO;
        case (idx)
            ACC_IDX_CHOP:   rd_mux = chop_reg;
            ACC_IDX_SPAREA: rd_mux = sparea_reg;
            ACC_IDX_SPAREB: rd_mux = spareb_reg & ACC_MASK_SPAREB;
            ACC_IDX_CH0CFG: rd_mux = ch0cfg_reg & ACC_MASK_CH0CFG;
            ACC_IDX_OFSHI:  rd_mux = ofshi_reg;
            ACC_IDX_OFSLO:  rd_mux = ofslo_reg & ACC_MASK_OFSLO;
            ACC_IDX_GAINHI: rd_mux = gainhi_reg;
            default:        rd_mux = ACC_RST_ZERO;
        endcase
    end

    // One wait state: ready rises in the second access cycle
    // Registering ready keeps the bus answer glitch free
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= PSEL && PENABLE && !pready_reg;
        end
    end

    // Error flag rides with ready for unmapped addresses
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= PSEL && PENABLE && !pready_reg && !hit;
        end
    end

    // Read data captured alongside ready; zero otherwise
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prdata_reg <= '0;
        end else if (PSEL && PENABLE && !pready_reg && !PWRITE && hit) begin
            prdata_reg <= {16'h0000, rd_mux};
        end else begin
            prdata_reg <= '0;
        end
    end

    // Chop configuration word
    // Reserved fields are stored as written; host keeps them zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            chop_reg <= ACC_RST_CHOP;
        end else if (wr_stb && idx == ACC_IDX_CHOP) begin
            chop_reg <= wdata;
        end
    end

    // Spare word a, plain read/write storage
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sparea_reg <= ACC_RST_ZERO;
        end else if (wr_stb && idx == ACC_IDX_SPAREA) begin
            sparea_reg <= wdata & ACC_MASK_ALL;
        end
    end

    // Spare word b; bits 7:4 never store
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            spareb_reg <= ACC_RST_ZERO;
        end else if (wr_stb && idx == ACC_IDX_SPAREB) begin
            spareb_reg <= wdata & ACC_MASK_SPAREB;
        end
    end

    // Channel-0 configuration; bits 5:3 never store
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ch0cfg_reg <= ACC_RST_ZERO;
        end else if (wr_stb && idx == ACC_IDX_CH0CFG) begin
            ch0cfg_reg <= wdata & ACC_MASK_CH0CFG;
        end
    end

    // Offset bits 23:8, full word
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ofshi_reg <= ACC_RST_ZERO;
        end else if (wr_stb && idx == ACC_IDX_OFSHI) begin
            ofshi_reg <= wdata;
        end
    end

    // Offset bits 7:0 in the upper byte; low byte read-only
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ofslo_reg <= ACC_RST_ZERO;
        end else if (wr_stb && idx == ACC_IDX_OFSLO) begin
            ofslo_reg <= wdata & ACC_MASK_OFSLO;
        end
    end

    // Gain bits 23:8; reset gives a mid-range gain of one
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            gainhi_reg <= ACC_RST_GAINHI;
        end else if (wr_stb && idx == ACC_IDX_GAINHI) begin
            gainhi_reg <= wdata;
        end
    end

    // Delay code to modulator periods
    // Code 1110b is undefined; it continues the doubling
    always_comb begin
        dly_cnt = ACC_BASE_CNT << chop_reg[ACC_DLY_MSB:ACC_DLY_LSB];
        if (chop_reg[ACC_DLY_MSB:ACC_DLY_LSB] == ACC_DLY_ODD) begin
            dly_cnt = ACC_ODD_CNT;
        end
    end

    // Settle timer: after a chop phase flip, wait the delay
    // Counts modulator ticks, not system clocks
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_reg <= ACC_IDLE;
        end else begin
            case (state_reg)
                ACC_IDLE: begin
                    if (PHASE_FLIP && chop_reg[ACC_CHOP_EN_BIT]) begin
                        state_reg <= ACC_SETTLE;
                    end
                end
                ACC_SETTLE: begin
                    // Chop off abandons the wait at once
                    if (!chop_reg[ACC_CHOP_EN_BIT]) begin
                        state_reg <= ACC_IDLE;
                    end else if (MOD_TICK && cnt_reg <= 17'h00001
                                 && !PHASE_FLIP) begin
                        state_reg <= ACC_IDLE;
                    end
                end
                default: state_reg <= ACC_IDLE;
            endcase
        end
    end

    // Remaining periods; a new flip restarts the wait
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cnt_reg <= '0;
        end else if (PHASE_FLIP) begin
            cnt_reg <= dly_cnt;
        end else if (state_reg == ACC_SETTLE && MOD_TICK
                     && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 17'h00001;
        end
    end

    // Shadow to active on conversion start
    // Mid-conversion writes never tear a running result
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ofs_act_reg  <= '0;
            gain_act_reg <= {ACC_RST_GAINHI, 8'h00};
            sel_act_reg  <= '0;
        end else if (CONV_START) begin
            ofs_act_reg  <= {ofshi_reg, ofslo_reg[ACC_LOB_MSB:ACC_LOB_LSB]};
            gain_act_reg <= {gainhi_reg, 8'h00};
            sel_act_reg  <= ch0cfg_reg[ACC_SEL_MSB:ACC_SEL_LSB];
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA                = prdata_reg;
    assign PREADY                = pready_reg;
    assign PSLVERR               = pslverr_reg;
    assign CHOP_MODE_ON          = chop_reg[ACC_CHOP_EN_BIT];
    assign CHOP_SETTLE_DELAY     = chop_reg[ACC_DLY_MSB:ACC_DLY_LSB];
    assign CHOP_SETTLING         = (state_reg == ACC_SETTLE);
    assign CHANNEL0_INPUT_SELECT = sel_act_reg;
    assign CHANNEL0_OFFSET       = ofs_act_reg;
    assign CHANNEL0_GAIN         = gain_act_reg;

endmodule // acc_regs
`default_nettype wire

// [tb/acc_regs_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module acc_regs_checker
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    // Bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Timing and outputs
    input wire logic        CONV_START,
    input wire logic        PHASE_FLIP,
    input wire logic        CHOP_MODE_ON,
    input wire logic        CHOP_SETTLING,
    input wire logic [1:0]  CHANNEL0_INPUT_SELECT,
    input wire logic [23:0] CHANNEL0_OFFSET,
    input wire logic [23:0] CHANNEL0_GAIN
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Exactly one wait state after the setup cycle
    property p_wait; PSEL && !PENABLE |=> !PREADY ##1 PREADY; endproperty
    a_wait: assert property (p_wait) else $error("ready not in second access cycle");
    property p_pulse; PREADY |=> !PREADY; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err; PSLVERR |-> PREADY; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    // Registers are 16 bits wide
    property p_upper; PRDATA[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read data not zero");
    property p_ofslo; PREADY && !PWRITE && PADDR == 32'h2c |-> PRDATA[7:0] == 8'h00; endproperty
    a_ofslo: assert property (p_ofslo) else $error("offset low byte not zero");
    property p_ro; PREADY && !PWRITE && PADDR == 32'h24 |-> PRDATA[5:3] == 3'h0; endproperty
    a_ro: assert property (p_ro) else $error("channel config read-only bits set");
    property p_gain; CHANNEL0_GAIN[7:0] == 8'h00; endproperty
    a_gain: assert property (p_gain) else $error("gain low byte not zero");
    // Active values move only on a conversion start
    property p_hold; !CONV_START |=> $stable(CHANNEL0_OFFSET) && $stable(CHANNEL0_GAIN)
        && $stable(CHANNEL0_INPUT_SELECT); endproperty
    a_hold: assert property (p_hold) else $error("active value changed without conversion");
    property p_flip; PHASE_FLIP && CHOP_MODE_ON |=> CHOP_SETTLING; endproperty
    a_flip: assert property (p_flip) else $error("settle wait not started");
    property p_off; !CHOP_MODE_ON |=> !CHOP_SETTLING; endproperty
    a_off: assert property (p_off) else $error("settling with chop off");
endmodule // acc_regs_checker
bind acc_regs acc_regs_checker acc_regs_checker_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONV_START(CONV_START), .PHASE_FLIP(PHASE_FLIP), .CHOP_MODE_ON(CHOP_MODE_ON),
    .CHOP_SETTLING(CHOP_SETTLING), .CHANNEL0_INPUT_SELECT(CHANNEL0_INPUT_SELECT),
    .CHANNEL0_OFFSET(CHANNEL0_OFFSET), .CHANNEL0_GAIN(CHANNEL0_GAIN));
`default_nettype wire

// [tb/acc_host.sv]
`timescale 1ns/10ps
`default_nettype none
module acc_host (
    // Clock
    input wire logic         clk,
    // Bus request
    output var logic         psel,
    output var logic         penable,
    output var logic         pwrite,
    output var logic [31:0]  paddr,
    output var logic [31:0]  pwdata,
    // Bus answer
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
    end
    // One transfer; callers keep reserved fields zero
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [15:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        // Wait as long as the slave needs; the bench watchdog cuts a hang
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not look valid
        paddr <= ~a;
        pwdata <= ~{16'h0000, d};
    endtask
endmodule // acc_host
`default_nettype wire

// [tb/acc_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module acc_regs_tb_top import acc_pkg::*;;
    logic sys_clk = 1'b0, rst_n = 1'b0, conv = 1'b0, tick = 1'b0, flip = 1'b0, er, on_o, stl;
    wire logic psel, pen, pwr, prdy, perr;
    wire logic [31:0] padr, pwd, prd;
    logic [31:0] rd;
    logic [3:0] dly;
    logic [1:0] sel;
    logic [23:0] ofs, gain;
    int num_errors = 0, comparisons = 0;
    logic [15:0] rst_tbl [0:6] = '{16'h0600, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
    always #20 sys_clk = ~sys_clk;
    acc_host acc_host_inst (.clk(sys_clk), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(padr),
        .pwdata(pwd), .prdata(prd), .pready(prdy), .pslverr(perr));
    acc_regs acc_regs_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .CONV_START(conv),
        .MOD_TICK(tick), .PHASE_FLIP(flip), .CHOP_MODE_ON(on_o), .CHOP_SETTLE_DELAY(dly),
        .CHOP_SETTLING(stl), .CHANNEL0_INPUT_SELECT(sel), .CHANNEL0_OFFSET(ofs), .CHANNEL0_GAIN(gain));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] i, input logic [15:0] e);
        acc_host_inst.xfer(1'b0, {26'h0, i, 2'b00}, 16'h0000, rd, er);
        chk(rd, {16'h0000, e});
    endtask
    task automatic wr(input logic [3:0] i, input logic [15:0] d);
        acc_host_inst.xfer(1'b1, {26'h0, i, 2'b00}, d, rd, er);
    endtask
    // Conversion start; active values land one cycle later
    task automatic start_conv;
        @(posedge sys_clk) conv <= 1'b1;
        @(posedge sys_clk) conv <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 7; i++) rchk(ACC_IDX_CHOP + 4'(i), rst_tbl[i]);
        chk(32'(dly), 32'h3);
        chk(32'(on_o), 32'h0);
        chk(32'(gain), 32'h800000);
    endtask
    task automatic t_cal;
        wr(ACC_IDX_OFSHI, 16'h8123);
        wr(ACC_IDX_OFSLO, 16'h4500);
        wr(ACC_IDX_GAINHI, 16'h7ffe);
        wr(ACC_IDX_CH0CFG, 16'h0002);
        chk(32'(ofs), 32'h0);
        start_conv();
        chk(32'(ofs), 32'h812345);
        chk(32'(gain), 32'h7ffe00);
        rchk(ACC_IDX_OFSLO, 16'h4500);
        for (int k = 0; k < 4; k++) begin
            wr(ACC_IDX_CH0CFG, 16'(k));
            start_conv();
            chk(32'(sel), 32'(k));
        end
        // Unmapped and misaligned places are refused
        acc_host_inst.xfer(1'b0, 32'h34, 16'h0000, rd, er);
        chk({rd[31:1], er}, 32'h1);
        acc_host_inst.xfer(1'b1, 32'h1a, 16'h0100, rd, er);
        rchk(ACC_IDX_CHOP, 16'h0600);
    endtask
    task automatic t_settle;
        int n;
        for (int k = 0; k < 3; k++) begin
            wr(ACC_IDX_CHOP, 16'(k << 9) | 16'h0100);
            @(negedge sys_clk);
            chk(32'(dly), 32'(k));
            @(posedge sys_clk) flip <= 1'b1;
            @(posedge sys_clk) flip <= 1'b0;
            n = 0;
            do begin
                @(posedge sys_clk) tick <= 1'b1;
                @(posedge sys_clk) tick <= 1'b0;
                n++;
                @(negedge sys_clk);
            end while (stl === 1'b1 && n < 100);
            chk(32'(n), 32'(2 << k));
        end
        wr(ACC_IDX_CHOP, 16'h0000);
        @(posedge sys_clk) flip <= 1'b1;
        @(posedge sys_clk) flip <= 1'b0;
        @(negedge sys_clk);
        chk(32'(stl), 32'h0);
    endtask
    task automatic end_of_test;
        $display("Errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #800000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_cal();
        t_settle();
        end_of_test();
    end
endmodule // acc_regs_tb_top
`default_nettype wire
